// ---- rtl/frame_timer_regs.vh ----
// Constants for the frame timer and its event generators
`ifndef FRAME_TIMER_REGS_VH
`define FRAME_TIMER_REGS_VH

// ----------------------------------------------------------------
// Sync source select codes
// ----------------------------------------------------------------
`define SYNC_SEL_W 3
`define SYNC_SEL_RP1 3'h0
`define SYNC_SEL_PIN 3'h1
`define SYNC_SEL_SW 3'h2
`define SYNC_SEL_RXFB 3'h3
`define SYNC_SEL_CMP 3'h4

// ----------------------------------------------------------------
// Event strobe select codes
// ----------------------------------------------------------------
`define STB_SEL_W 3
`define STB_SEL_RAD_SYM 3'h0
`define STB_SEL_RAD_FRM 3'h1
`define STB_SEL_UL_SYM 3'h2
`define STB_SEL_UL_FRM 3'h3
`define STB_SEL_DL_SYM 3'h4
`define STB_SEL_DL_FRM 3'h5

// ----------------------------------------------------------------
// Default widths and counts
// ----------------------------------------------------------------
`define CLK_CNT_W 20
`define SYM_CNT_W 8
`define FRM_CNT_W 12
`define EVT_CNT_W 24
`define NUM_EVENTS 11

`endif

// ---- rtl/boundary_timer.v ----
// One frame timer: clock, symbol and frame counts with boundary strobes
`timescale 1ns/1ps
`default_nettype none
module boundary_timer #(
  parameter CLK_W = 20,
  parameter SYM_W = 8,
  parameter FRM_W = 12
) (
  input wire core_clk, // Processing clock
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable
  input wire sync_pulse, // Realign frame boundary
  input wire [CLK_W-1:0] term_clk, // Clocks per symbol minus one
  input wire [SYM_W-1:0] term_sym, // Symbols per frame minus one
  input wire [FRM_W-1:0] term_frm, // Frames per wrap minus one
  output reg [CLK_W-1:0] clk_cnt_reg, // Clock count
  output reg [SYM_W-1:0] sym_cnt_reg, // Symbol count
  output reg [FRM_W-1:0] frm_cnt_reg, // Frame count
  output reg sym_strobe_reg, // Symbol boundary pulse
  output reg frm_strobe_reg // Frame boundary pulse
);

  // ----------------------------------------------------------------
  // Counting and wrap
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_cnt_reg <= {CLK_W{1'b0}};
      sym_cnt_reg <= {SYM_W{1'b0}};
      frm_cnt_reg <= {FRM_W{1'b0}};
      sym_strobe_reg <= 1'b0;
      frm_strobe_reg <= 1'b0;
    end else if (ce) begin
      if (sync_pulse) begin
        // Sync forces a fresh frame and symbol
        clk_cnt_reg <= {CLK_W{1'b0}};
        sym_cnt_reg <= {SYM_W{1'b0}};
        frm_cnt_reg <= {FRM_W{1'b0}};
        sym_strobe_reg <= 1'b1;
        frm_strobe_reg <= 1'b1;
      end else if (clk_cnt_reg == term_clk) begin
        clk_cnt_reg <= {CLK_W{1'b0}};
        sym_strobe_reg <= 1'b1;
        if (sym_cnt_reg == term_sym) begin
          sym_cnt_reg <= {SYM_W{1'b0}};
          frm_strobe_reg <= 1'b1;
          if (frm_cnt_reg == term_frm) begin
            frm_cnt_reg <= {FRM_W{1'b0}};
          end else begin
            frm_cnt_reg <= frm_cnt_reg + 1'b1;
          end
        end else begin
          sym_cnt_reg <= sym_cnt_reg + 1'b1;
          frm_strobe_reg <= 1'b0;
        end
      end else begin
        clk_cnt_reg <= clk_cnt_reg + 1'b1;
        sym_strobe_reg <= 1'b0;
        frm_strobe_reg <= 1'b0;
      end
    end
  end

endmodule // boundary_timer
`default_nettype wire

// ---- rtl/frame_timer_event_generator.v ----
// Frame timer with link, radio, uplink, downlink timers and event generators
`timescale 1ns/1ps
`include "frame_timer_regs.vh"
`default_nettype none
module frame_timer_event_generator #(
  parameter CLK_W = `CLK_CNT_W,
  parameter SYM_W = `SYM_CNT_W,
  parameter FRM_W = `FRM_CNT_W,
  parameter EW = `EVT_CNT_W,
  parameter NUM_EVT = `NUM_EVENTS
) (
  input wire core_clk, // Processing clock, 125 MHz
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable, freezes all state
  // Sync sources
  input wire rp1_sync_input, // RP1 frame burst pin
  input wire link_sync_input, // Link sync pin
  input wire radio_sync_input, // Radio sync pin
  input wire software_sync_trigger, // Software sync pulse
  input wire rx_frame_boundary, // Received frame boundary pulse
  // Configuration
  input wire [2:0] link_sync_sel, // Link sync source code
  input wire [2:0] radio_sync_sel, // Radio sync source code
  input wire link_sync_to_radio, // Link sync also syncs radio
  input wire radio_sync_to_link, // Radio sync also syncs link
  input wire [CLK_W-1:0] radio_sync_compare_value, // Link clock compare
  input wire [CLK_W-1:0] link_term_clk, // Link clocks per symbol - 1
  input wire [SYM_W-1:0] link_term_sym, // Link symbols per frame - 1
  input wire [FRM_W-1:0] link_term_frm, // Link frames per wrap - 1
  input wire [CLK_W-1:0] radio_term_clk, // Radio clocks per symbol - 1
  input wire [SYM_W-1:0] radio_term_sym, // Radio symbols per frame - 1
  input wire [FRM_W-1:0] radio_term_frm, // Radio frames per wrap - 1
  input wire [EW-1:0] uplink_offset, // Uplink lag in clocks
  input wire [EW-1:0] downlink_offset, // Downlink lag in clocks
  // Event generator configuration, one field per event
  input wire [3*NUM_EVT-1:0] event_strobe_sel, // Strobe select codes
  input wire [EW*NUM_EVT-1:0] event_offset, // Trigger offsets
  input wire [EW*NUM_EVT-1:0] event_modulo, // Modulo periods - 1
  input wire [NUM_EVT-1:0] event_enable, // Enable requests
  // Timer outputs
  output wire [CLK_W-1:0] link_clk_count, // Link clock count
  output wire [SYM_W-1:0] link_sym_count, // Link symbol count
  output wire [FRM_W-1:0] link_frm_count, // Link frame count
  output wire link_symbol_strobe, // Link symbol boundary
  output wire link_frame_strobe, // Link frame boundary
  output wire [CLK_W-1:0] radio_clk_count, // Radio clock count
  output wire [SYM_W-1:0] radio_sym_count, // Radio symbol count
  output wire [FRM_W-1:0] radio_frm_count, // Radio frame count
  output wire radio_symbol_strobe, // Radio symbol boundary
  output wire radio_frame_strobe, // Radio frame boundary
  output wire uplink_symbol_strobe, // Uplink symbol boundary
  output wire uplink_frame_strobe, // Uplink frame boundary
  output wire downlink_symbol_strobe, // Downlink symbol boundary
  output wire downlink_frame_strobe, // Downlink frame boundary
  output wire radio_compare_armed, // Compare sync waiting
  output wire [NUM_EVT-1:0] event_running, // Event active status
  output wire [NUM_EVT-1:0] event_out // Event pulses
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  reg [2:0] pin_ff1_reg;
  reg [2:0] pin_ff2_reg;
  reg [2:0] pin_ff3_reg;
  wire [2:0] pin_rise;

  // Two flops per pin, third for edge detect
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_ff1_reg <= 3'h0;
      pin_ff2_reg <= 3'h0;
      pin_ff3_reg <= 3'h0;
    end else if (ce) begin
      pin_ff1_reg <= {radio_sync_input, link_sync_input, rp1_sync_input};
      pin_ff2_reg <= pin_ff1_reg;
      pin_ff3_reg <= pin_ff2_reg;
    end
  end

  assign pin_rise = pin_ff2_reg & ~pin_ff3_reg;

  // ----------------------------------------------------------------
  // Sync source selection
  // ----------------------------------------------------------------
  reg link_src_sync;
  reg radio_src_sync;
  reg cmp_armed_reg;
  wire cmp_hit;
  wire link_sync_pulse;
  wire radio_sync_pulse;
  wire [CLK_W-1:0] lk_clk_cnt;

  // Link timer source by select code
  always @* begin
    case (link_sync_sel)
      `SYNC_SEL_RP1: link_src_sync = pin_rise[0];
      `SYNC_SEL_PIN: link_src_sync = pin_rise[1];
      `SYNC_SEL_SW: link_src_sync = software_sync_trigger;
      `SYNC_SEL_RXFB: link_src_sync = rx_frame_boundary;
      default: link_src_sync = 1'b0;
    endcase
  end

  // Radio timer source by select code
  always @* begin
    case (radio_sync_sel)
      `SYNC_SEL_RP1: radio_src_sync = pin_rise[0];
      `SYNC_SEL_PIN: radio_src_sync = pin_rise[2];
      `SYNC_SEL_SW: radio_src_sync = software_sync_trigger;
      `SYNC_SEL_RXFB: radio_src_sync = rx_frame_boundary;
      `SYNC_SEL_CMP: radio_src_sync = cmp_hit;
      default: radio_src_sync = 1'b0;
    endcase
  end

  // Cross routing lets one trigger start both timers
  assign link_sync_pulse = link_src_sync |
                           (radio_sync_to_link & radio_src_sync);
  assign radio_sync_pulse = radio_src_sync |
                            (link_sync_to_radio & link_src_sync);

  // ----------------------------------------------------------------
  // Compare-based radio sync
  // ----------------------------------------------------------------
  assign cmp_hit = cmp_armed_reg &
                   (lk_clk_cnt == radio_sync_compare_value);

  // Armed by a link sync, fires once at the compare value
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_armed_reg <= 1'b0;
    end else if (ce) begin
      if (radio_sync_sel != `SYNC_SEL_CMP) begin
        cmp_armed_reg <= 1'b0;
      end else if (link_sync_pulse) begin
        cmp_armed_reg <= 1'b1;
      end else if (cmp_hit) begin
        cmp_armed_reg <= 1'b0;
      end
    end
  end

  assign radio_compare_armed = cmp_armed_reg;

  // ----------------------------------------------------------------
  // Link and radio timers, both on core_clk
  // ----------------------------------------------------------------
  // Link timer gives the base for the compare-based radio sync
  boundary_timer #(.CLK_W(CLK_W), .SYM_W(SYM_W), .FRM_W(FRM_W)) u_link (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .sync_pulse(link_sync_pulse),
    .term_clk(link_term_clk),
    .term_sym(link_term_sym),
    .term_frm(link_term_frm),
    .clk_cnt_reg(lk_clk_cnt),
    .sym_cnt_reg(link_sym_count),
    .frm_cnt_reg(link_frm_count),
    .sym_strobe_reg(link_symbol_strobe),
    .frm_strobe_reg(link_frame_strobe)
  );

  assign link_clk_count = lk_clk_cnt;

  // Radio timer follows the radio frame layout
  boundary_timer #(.CLK_W(CLK_W), .SYM_W(SYM_W), .FRM_W(FRM_W)) u_radio (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .sync_pulse(radio_sync_pulse),
    .term_clk(radio_term_clk),
    .term_sym(radio_term_sym),
    .term_frm(radio_term_frm),
    .clk_cnt_reg(radio_clk_count),
    .sym_cnt_reg(radio_sym_count),
    .frm_cnt_reg(radio_frm_count),
    .sym_strobe_reg(radio_symbol_strobe),
    .frm_strobe_reg(radio_frame_strobe)
  );

  // ----------------------------------------------------------------
  // Uplink and downlink offset copies of the radio timer
  // ----------------------------------------------------------------
  wire [1:0] dir_sync;
  wire [1:0] dir_sym_stb;
  wire [1:0] dir_frm_stb;
  wire [2*EW-1:0] dir_offset;

  assign dir_offset = {downlink_offset, uplink_offset};

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : g_dir
      reg [EW-1:0] lag_cnt_reg;
      reg lag_act_reg;

      // Count the offset from each radio frame boundary
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          lag_cnt_reg <= {EW{1'b0}};
          lag_act_reg <= 1'b0;
        end else if (ce) begin
          if (radio_frame_strobe) begin
            lag_cnt_reg <= dir_offset[d*EW +: EW];
            lag_act_reg <= 1'b1;
          end else if (lag_act_reg) begin
            if (lag_cnt_reg == {EW{1'b0}}) begin
              lag_act_reg <= 1'b0;
            end else begin
              lag_cnt_reg <= lag_cnt_reg - 1'b1;
            end
          end
        end
      end

      assign dir_sync[d] = lag_act_reg & (lag_cnt_reg == {EW{1'b0}});

      // Offset copy shares the radio terminal counts
      boundary_timer #(.CLK_W(CLK_W), .SYM_W(SYM_W), .FRM_W(FRM_W)) u_dir (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .sync_pulse(dir_sync[d]),
        .term_clk(radio_term_clk),
        .term_sym(radio_term_sym),
        .term_frm(radio_term_frm),
        .clk_cnt_reg(),
        .sym_cnt_reg(),
        .frm_cnt_reg(),
        .sym_strobe_reg(dir_sym_stb[d]),
        .frm_strobe_reg(dir_frm_stb[d])
      );
    end
  endgenerate

  assign uplink_symbol_strobe = dir_sym_stb[0];
  assign uplink_frame_strobe = dir_frm_stb[0];
  assign downlink_symbol_strobe = dir_sym_stb[1];
  assign downlink_frame_strobe = dir_frm_stb[1];

  // ----------------------------------------------------------------
  // Counter-based event generators
  // ----------------------------------------------------------------
  wire [5:0] strobe_bus;

  assign strobe_bus = {downlink_frame_strobe, downlink_symbol_strobe,
                       uplink_frame_strobe, uplink_symbol_strobe,
                       radio_frame_strobe, radio_symbol_strobe};

  genvar e;
  generate
    for (e = 0; e < NUM_EVT; e = e + 1) begin : g_evt
      wire [2:0] sel;
      reg stb;
      reg run_reg;
      reg dly_act_reg;
      reg mod_act_reg;
      reg [EW-1:0] dly_reg;
      reg [EW-1:0] mod_reg;
      reg fire_reg;

      assign sel = event_strobe_sel[3*e +: 3];

      // Input strobe choice
      always @* begin
        case (sel)
          `STB_SEL_RAD_SYM: stb = strobe_bus[0];
          `STB_SEL_RAD_FRM: stb = strobe_bus[1];
          `STB_SEL_UL_SYM: stb = strobe_bus[2];
          `STB_SEL_UL_FRM: stb = strobe_bus[3];
          `STB_SEL_DL_SYM: stb = strobe_bus[4];
          `STB_SEL_DL_FRM: stb = strobe_bus[5];
          default: stb = 1'b0;
        endcase
      end

      // Offset delay, then modulo repeats until next boundary
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          run_reg <= 1'b0;
          dly_act_reg <= 1'b0;
          mod_act_reg <= 1'b0;
          dly_reg <= {EW{1'b0}};
          mod_reg <= {EW{1'b0}};
          fire_reg <= 1'b0;
        end else if (ce) begin
          fire_reg <= 1'b0;
          if (stb) begin
            // Enable changes take hold only here
            run_reg <= event_enable[e];
            dly_act_reg <= event_enable[e];
            mod_act_reg <= 1'b0;
            dly_reg <= event_offset[EW*e +: EW];
          end else if (run_reg && dly_act_reg) begin
            if (dly_reg == {EW{1'b0}}) begin
              fire_reg <= 1'b1;
              dly_act_reg <= 1'b0;
              mod_act_reg <= 1'b1;
              mod_reg <= event_modulo[EW*e +: EW];
            end else begin
              dly_reg <= dly_reg - 1'b1;
            end
          end else if (run_reg && mod_act_reg) begin
            if (mod_reg == {EW{1'b0}}) begin
              fire_reg <= 1'b1;
              mod_reg <= event_modulo[EW*e +: EW];
            end else begin
              mod_reg <= mod_reg - 1'b1;
            end
          end
        end
      end

      assign event_out[e] = fire_reg;
      assign event_running[e] = run_reg;
    end
  endgenerate

endmodule // frame_timer_event_generator
`default_nettype wire

// ---- tb/sync_pin_model.sv ----
// Model of the external sync pins that feed the frame timer
`timescale 1ns/1ps
`default_nettype none
module sync_pin_model (
  input wire logic core_clk, // Bench clock
  input wire logic rst, // Async reset, active high
  input wire logic [2:0] fire_req, // Raise pin: 0 rp1, 1 link, 2 radio
  output logic [2:0] pin_out // Pin levels
);
  logic [2:0] hold_reg [0:2];
  integer i;
  // ------------------------------------------------------------
  // Pin pulses
  // ------------------------------------------------------------
  // Pins rise together or apart and stay high so two flops see them
  always @(posedge core_clk or posedge rst) begin
    for (i = 0; i < 3; i = i + 1) begin
      if (rst) begin
        hold_reg[i] <= 3'h0;
      end else if (fire_req[i]) begin
        hold_reg[i] <= 3'h4;
      end else if (hold_reg[i] != 3'h0) begin
        hold_reg[i] <= hold_reg[i] - 3'h1;
      end
    end
  end
  // Pin is high while its hold count runs
  assign pin_out = {hold_reg[2] != 3'h0, hold_reg[1] != 3'h0,
                    hold_reg[0] != 3'h0};
endmodule // sync_pin_model
`default_nettype wire

// ---- tb/frame_timer_chk.sv ----
// Port-level assertions for the frame timer and event generators
`timescale 1ns/1ps
`default_nettype none
`include "frame_timer_regs.vh"
module frame_timer_chk #(
  parameter CLK_W = 20,
  parameter SYM_W = 8,
  parameter NUM_EVT = 11
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic ce, // Clock enable
  input wire logic software_sync_trigger, // Software sync
  input wire logic rx_frame_boundary, // Received frame boundary
  input wire logic [2:0] link_sync_sel, // Link source code
  input wire logic [2:0] radio_sync_sel, // Radio source code
  input wire logic [CLK_W-1:0] radio_sync_compare_value, // Compare value
  input wire logic [CLK_W-1:0] link_term_clk, // Link terminal count
  input wire logic [CLK_W-1:0] link_clk_count, // Link clock count
  input wire logic [SYM_W-1:0] link_sym_count, // Link symbol count
  input wire logic link_symbol_strobe, // Link symbol strobe
  input wire logic link_frame_strobe, // Link frame strobe
  input wire logic [CLK_W-1:0] radio_clk_count, // Radio clock count
  input wire logic radio_symbol_strobe, // Radio symbol strobe
  input wire logic radio_frame_strobe, // Radio frame strobe
  input wire logic uplink_frame_strobe, // Uplink frame strobe
  input wire logic radio_compare_armed, // Compare waiting
  input wire logic [3*NUM_EVT-1:0] event_strobe_sel, // Strobe selects
  input wire logic [NUM_EVT-1:0] event_running, // Event active
  input wire logic [NUM_EVT-1:0] event_out // Event pulses
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_LINK_SW_SYNC: assert property (ce && software_sync_trigger &&
    link_sync_sel == `SYNC_SEL_SW |=> link_clk_count == 0 &&
    link_symbol_strobe && link_frame_strobe) else $error("link sw sync");
  AST_LINK_RX_SYNC: assert property (ce && rx_frame_boundary &&
    link_sync_sel == `SYNC_SEL_RXFB |=> link_clk_count == 0 &&
    link_frame_strobe) else $error("link rx sync");
  AST_RADIO_SW_SYNC: assert property (ce && software_sync_trigger &&
    radio_sync_sel == `SYNC_SEL_SW |=> radio_clk_count == 0 &&
    radio_frame_strobe) else $error("radio sw sync");
  AST_LINK_WRAP: assert property (ce &&
    link_clk_count == link_term_clk |=> link_clk_count == 0 &&
    link_symbol_strobe) else $error("link wrap");
  AST_SYM_AT_ZERO: assert property (link_symbol_strobe |->
    link_clk_count == 0) else $error("symbol strobe off zero");
  AST_FRM_WITH_SYM: assert property (link_frame_strobe |->
    link_symbol_strobe && link_sym_count == 0) else $error("frame strobe");
  AST_CMP_SYNC: assert property (ce && radio_compare_armed &&
    radio_sync_sel == `SYNC_SEL_CMP &&
    link_clk_count == radio_sync_compare_value |=> radio_clk_count == 0
    && !radio_compare_armed) else $error("compare sync");
  AST_CE_FREEZE: assert property (!ce |=> $stable(link_clk_count) &&
    $stable(radio_clk_count)) else $error("freeze");
  AST_EVT_START: assert property (event_running[0] &&
    !$past(event_running[0]) && event_strobe_sel[2:0] == `STB_SEL_RAD_SYM
    |-> $past(radio_symbol_strobe)) else $error("event start");
  COV_CMP: cover property (radio_compare_armed ##1 !radio_compare_armed);
  COV_EVT: cover property (event_out[0]);
  COV_UL: cover property (uplink_frame_strobe);
endmodule // frame_timer_chk
bind frame_timer_event_generator frame_timer_chk #(.CLK_W(CLK_W),
  .SYM_W(SYM_W), .NUM_EVT(NUM_EVT)) u_chk (.core_clk(core_clk), .rst(rst),
  .ce(ce), .software_sync_trigger(software_sync_trigger),
  .rx_frame_boundary(rx_frame_boundary), .link_sync_sel(link_sync_sel),
  .radio_sync_sel(radio_sync_sel),
  .radio_sync_compare_value(radio_sync_compare_value),
  .link_term_clk(link_term_clk), .link_clk_count(link_clk_count),
  .link_sym_count(link_sym_count), .link_symbol_strobe(link_symbol_strobe),
  .link_frame_strobe(link_frame_strobe), .radio_clk_count(radio_clk_count),
  .radio_symbol_strobe(radio_symbol_strobe),
  .radio_frame_strobe(radio_frame_strobe),
  .uplink_frame_strobe(uplink_frame_strobe),
  .radio_compare_armed(radio_compare_armed),
  .event_strobe_sel(event_strobe_sel), .event_running(event_running),
  .event_out(event_out));
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the frame timer and event generators
`timescale 1ns/1ps
`default_nettype none
`include "frame_timer_regs.vh"
module testbench;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, sw = 1'b0, rxfb = 1'b0;
  logic [2:0] lsel = 3'h2, rsel = 3'h7, fire = 3'h0;
  logic l2r = 1'b0, r2l = 1'b0;
  logic [19:0] cmpv = 20'h00002, tclk = 20'h0000F;
  logic [7:0] tsym = 8'h01;
  logic [11:0] lfrm = 12'h002, rfrm = 12'h001;
  logic [23:0] ul_off = 24'h000005, dl_off = 24'h000009;
  logic [32:0] ev_sel;
  logic [263:0] ev_off, ev_mod;
  logic [10:0] ev_en = 11'h03F, ev_run, ev_out;
  wire [2:0] pins;
  wire [19:0] lclk, rclk;
  wire [7:0] lsym, rsym;
  wire [11:0] lfc, rfc;
  wire lss, lfs, rss, rfs, uss, ufs, dss, dfs, armed;
  int err_total = 0, check_count = 0, i;
  logic [19:0] held;
  logic found;
  // Free-running bench clock, 8 ns period
  always #4 core_clk = ~core_clk;
  sync_pin_model u_pins (.core_clk(core_clk), .rst(rst), .fire_req(fire),
    .pin_out(pins));
  frame_timer_event_generator uut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .rp1_sync_input(pins[0]), .link_sync_input(pins[1]),
    .radio_sync_input(pins[2]), .software_sync_trigger(sw),
    .rx_frame_boundary(rxfb), .link_sync_sel(lsel), .radio_sync_sel(rsel),
    .link_sync_to_radio(l2r), .radio_sync_to_link(r2l),
    .radio_sync_compare_value(cmpv), .link_term_clk(tclk),
    .link_term_sym(tsym), .link_term_frm(lfrm), .radio_term_clk(tclk),
    .radio_term_sym(tsym), .radio_term_frm(rfrm), .uplink_offset(ul_off),
    .downlink_offset(dl_off), .event_strobe_sel(ev_sel),
    .event_offset(ev_off), .event_modulo(ev_mod), .event_enable(ev_en),
    .link_clk_count(lclk), .link_sym_count(lsym), .link_frm_count(lfc),
    .link_symbol_strobe(lss), .link_frame_strobe(lfs),
    .radio_clk_count(rclk), .radio_sym_count(rsym), .radio_frm_count(rfc),
    .radio_symbol_strobe(rss), .radio_frame_strobe(rfs),
    .uplink_symbol_strobe(uss), .uplink_frame_strobe(ufs),
    .downlink_symbol_strobe(dss), .downlink_frame_strobe(dfs),
    .radio_compare_armed(armed), .event_running(ev_run), .event_out(ev_out));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Source 0 software, 1 received frame, 2..4 pins rp1, link, radio
  task pulse(input int src);
    @(posedge core_clk);
    if (src == 0) sw <= 1'b1;
    else if (src == 1) rxfb <= 1'b1;
    else fire[src-2] <= 1'b1;
    @(posedge core_clk);
    sw <= 1'b0;
    rxfb <= 1'b0;
    fire <= 3'h0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Sync one timer from a source code; expect a re-zero or none
  task sync_try(input bit radio, input logic [2:0] code, input logic exp);
    @(posedge core_clk);
    if (radio) rsel <= code;
    else lsel <= code;
    #1;
    while ((radio ? rclk : lclk) !== 20'h00003) tick(1);
    case (code)
      3'h0: pulse(2);
      3'h1: pulse(radio ? 4 : 3);
      3'h3: pulse(1);
      default: pulse(0);
    endcase
    found = 1'b0;
    repeat (8) begin
      #1;
      if ((radio ? rclk : lclk) === 20'h00000) found = 1'b1;
      @(posedge core_clk);
    end
    check("sync found", found, exp);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    for (i = 0; i < 11; i++) begin
      ev_sel[3*i+:3] = 3'(i % 6);
      ev_off[24*i+:24] = 24'h000000;
      ev_mod[24*i+:24] = 24'h00FFFF;
    end
    ev_off[23:0] = 24'h000002;
    ev_mod[23:0] = 24'h000003;
    tick(8);
    check("reset count", lclk, 0);
    @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    check("first count", lclk, 1);
    pulse(0);
    #1;
    check("sw sync", {lclk, lss, lfs}, {20'h0, 2'b11});
    tick(15);
    check("at term", {lclk, lss}, {20'h0000F, 1'b0});
    tick(1);
    check("sym wrap", {lclk, lsym, lss, lfs}, {20'h0, 8'h1, 2'b10});
    tick(16);
    check("frm wrap", {lsym, lfc, lfs}, {8'h0, 12'h1, 1'b1});
    for (i = 0; i < 5; i++) sync_try(1'b0, 3'(i), i < 4);
    for (i = 0; i < 6; i++) sync_try(1'b1, 3'(i), i != 4 && i < 5);
    @(posedge core_clk);
    lsel <= 3'h2;
    rsel <= 3'h4;
    pulse(0);
    #1;
    check("armed", armed, 1);
    tick(3);
    check("cmp sync", {rclk, armed, rfs}, {20'h0, 2'b01});
    check("radio counts", {rsym, rfc}, 20'h0);
    @(posedge core_clk);
    rsel <= 3'h7;
    l2r <= 1'b1;
    tick(5);
    pulse(0);
    #1;
    check("link to radio", rclk, 0);
    @(posedge core_clk);
    lsel <= 3'h7;
    rsel <= 3'h2;
    l2r <= 1'b0;
    r2l <= 1'b1;
    tick(5);
    pulse(0);
    #1;
    check("radio to link", {lclk, rfs}, {20'h0, 1'b1});
    tick(6);
    check("ul early", ufs, 0);
    tick(1);
    check("ul strobe", {ufs, uss}, 2'b11);
    tick(4);
    check("dl strobe", {dfs, dss}, 2'b11);
    pulse(0);
    #1;
    check("rad sym", rss, 1);
    tick(1);
    check("running", ev_run[0], 1);
    tick(2);
    check("before offset", ev_out[0], 0);
    tick(1);
    check("at offset", ev_out[0], 1);
    @(posedge core_clk);
    ev_en[0] <= 1'b0;
    tick(3);
    check("modulo", ev_out[0], 1);
    tick(4);
    check("after disable", ev_out[0], 1);
    tick(5);
    check("stopped", ev_run[0], 0);
    check("all selects", ev_run[5:1], 5'h1F);
    check("disabled", {ev_run[10:6], ev_out[10:6]}, 10'h0);
    @(posedge core_clk);
    ce <= 1'b0;
    tick(2);
    held = lclk;
    tick(3);
    check("freeze", lclk, held);
    @(posedge core_clk);
    ce <= 1'b1;
    tick(2);
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
